//--- sac_adc_ctrl.sv
// Converter control top: shared control/result address, refresh, channels.
// Assumes a single-cycle strobe register port and external ladder comparators.
//
// Functional notes
// - Refresh every 6144 oscillator periods in dual 4-bit, 12288 in 6-bit mode.
// - Reference steps are supply*N/16 in 4-bit mode, supply*N/64 in 6-bit mode.
// - Code is N with step N below pin and step N+1 above; 0-15 or 0-63.
// - Control bit 7 turns the converter on; cleared, no conversions occur.
// - Control bit 6 set selects one 6-bit converter on one of inputs 3..0.
// - Control bit 6 clear selects two 4-bit converters on inputs 1 and 0.
// - Control bits 3..0 enable input pins 3..0; write bits 5 and 4 ignored.
// - Dual mode read: channel 1 code in bits 7..4, channel 0 in 3..0.
// - Wide mode read: 6-bit code in bits 5..0, bits 7..6 meaningless.
// - Control and result share address A0h; reads never return control value.
`timescale 1ns/1ps
module sac_adc_ctrl #(
    parameter int REFRESH_NARROW_CYC = sac_pkg::SAC_REFRESH_NARROW_CYC,
    parameter int REFRESH_WIDE_CYC   = sac_pkg::SAC_REFRESH_WIDE_CYC,
    parameter int SETTLE_CYC         = sac_pkg::SAC_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                                     sys_clk,
    input  wire logic                                     resetn,
    // Register port
    input  wire sac_pkg::sac_bus_req_t                    bus_req,
    output logic [7:0]                                    rd_data,
    // Analog front end
    input  wire logic [sac_pkg::SAC_NUM_CH-1:0]           cmp_above,
    output logic [sac_pkg::SAC_NUM_CH-1:0]                pin_enable,
    output logic [sac_pkg::SAC_NUM_CH-1:0][5:0]           ref_code
);
    import sac_pkg::*;

    typedef enum logic {SAC_IDLE, SAC_CONV} sac_state_t;

    sac_state_t                  state_q, state_d;
    sac_ctrl_t                   ctrl_q, ctrl_d;
    logic [7:0]                  result_q, result_d;
    logic [7:0]                  rd_q, rd_d;
    logic [SAC_NUM_CH-1:0]       pend_q, pend_d;
    logic [SAC_NUM_CH-1:0]       active, start, done;
    logic [SAC_NUM_CH-1:0][5:0]  code;
    logic [1:0]                  sel;
    logic                        wr_hit, rd_hit, abort, tick, complete;

    // Lowest enabled input wins in wide mode; more than one is a software fault
    always_comb begin
        sel = 2'd0;
        for (int i = SAC_NUM_CH - 1; i >= 0; i--) begin
            if (ctrl_q.input_enable[i]) begin
                sel = 2'(i);
            end
        end
    end

    always_comb begin
        active = '0;
        if (!ctrl_q.converter_on) begin
            active = '0;
        end else if (ctrl_q.resolution_select) begin
            active[sel] = ctrl_q.input_enable[sel];
        end else begin
            active[1:0] = ctrl_q.input_enable[1:0];
        end
    end

    assign pin_enable = active;

    sac_refresh_timer #(
        .PERIOD_NARROW (REFRESH_NARROW_CYC),
        .PERIOD_WIDE   (REFRESH_WIDE_CYC),
        .CNT_W         (SAC_TIMER_W)
    ) u_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .run     (ctrl_q.converter_on),
        .wide    (ctrl_q.resolution_select),
        .restart (abort),
        .tick    (tick)
    );

    genvar g;
    generate
        for (g = 0; g < SAC_NUM_CH; g++) begin : g_chan
            sac_sar_chan #(
                .SETTLE (SETTLE_CYC)
            ) u_chan (
                .sys_clk   (sys_clk),
                .resetn    (resetn),
                .start     (start[g]),
                .abort     (abort),
                .wide      (ctrl_q.resolution_select),
                .cmp_above (cmp_above[g]),
                .ref_code  (ref_code[g]),
                .code      (code[g]),
                .done      (done[g])
            );
        end
    endgenerate

    always_comb begin
        state_d  = state_q;
        ctrl_d   = ctrl_q;
        result_d = result_q;
        pend_d   = pend_q;
        start    = '0;
        complete = 1'b0;
        abort    = 1'b0;
        wr_hit   = bus_req.wr && (bus_req.addr == SAC_CTRL_ADDR);
        rd_hit   = bus_req.rd && (bus_req.addr == SAC_CTRL_ADDR);
        // Reads see only results, never the control bits
        rd_d     = rd_hit ? result_q : SAC_IDLE_RDATA;
        if (wr_hit) begin
            ctrl_d.converter_on      = bus_req.wdata[SAC_ON_POS];
            ctrl_d.resolution_select = bus_req.wdata[SAC_MODE_POS];
            ctrl_d.input_enable      = bus_req.wdata[SAC_EN_LSB +: SAC_NUM_CH];
            // Any control write restarts the round so a result never mixes two settings
            abort = 1'b1;
        end
        case (state_q)
            SAC_IDLE: begin
                if (tick && !abort && (active != '0)) begin
                    start   = active;
                    pend_d  = active;
                    state_d = SAC_CONV;
                end
            end
            SAC_CONV: begin
                pend_d = pend_q & ~done;
                if (abort) begin
                    pend_d  = '0;
                    state_d = SAC_IDLE;
                end else if (pend_d == '0) begin
                    complete = 1'b1;
                    state_d  = SAC_IDLE;
                    if (ctrl_q.resolution_select) begin
                        result_d = {2'b00, code[sel]};
                    end else begin
                        if (active[1]) begin
                            result_d[7:4] = code[1][SAC_NARROW_W-1:0];
                        end
                        if (active[0]) begin
                            result_d[3:0] = code[0][SAC_NARROW_W-1:0];
                        end
                    end
                end
            end
            default: begin
                pend_d  = '0;
                state_d = SAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q  <= SAC_IDLE;
            ctrl_q   <= SAC_CTRL_RESET;
            result_q <= SAC_RESULT_RESET;
            rd_q     <= SAC_IDLE_RDATA;
            pend_q   <= '0;
        end else begin
            state_q  <= state_d;
            ctrl_q   <= ctrl_d;
            result_q <= result_d;
            rd_q     <= rd_d;
            pend_q   <= pend_d;
        end
    end

    assign rd_data = rd_q;

    // Helper: cycles since the last tick, for the period check
    logic [SAC_TIMER_W-1:0] gap_q;
    logic                   seen_q;

    always_ff @(posedge sys_clk) begin
        if (!resetn || abort || !ctrl_q.converter_on) begin
            gap_q  <= '0;
            seen_q <= 1'b0;
        end else if (tick) begin
            gap_q  <= '0;
            seen_q <= 1'b1;
        end else begin
            gap_q  <= gap_q + SAC_TIMER_W'(1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_refresh_period;
        tick && seen_q |-> gap_q == (ctrl_q.resolution_select ?
            SAC_TIMER_W'(REFRESH_WIDE_CYC - 1) : SAC_TIMER_W'(REFRESH_NARROW_CYC - 1));
    endproperty
    a_refresh_period: assert property (p_refresh_period)
        else $error("refresh tick spacing wrong");

    property p_narrow_ref;
        !ctrl_q.resolution_select && state_q == SAC_CONV && active[0] && !abort
            |=> ref_code[0][SAC_NARROW_SHIFT-1:0] == 2'b00;
    endproperty
    a_narrow_ref: assert property (p_narrow_ref)
        else $error("narrow reference not on a sixteenth step");

    property p_narrow_code;
        done[0] && !ctrl_q.resolution_select |-> code[0][5:4] == 2'b00;
    endproperty
    a_narrow_code: assert property (p_narrow_code)
        else $error("narrow code above fifteen");

    property p_off_idle;
        !ctrl_q.converter_on |-> start == '0 ##1 pend_q == '0;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("conversion started while converter off");

    property p_wide_single;
        ctrl_q.resolution_select |-> $onehot0(active);
    endproperty
    a_wide_single: assert property (p_wide_single)
        else $error("more than one wide channel active");

    property p_dual_pins;
        !ctrl_q.resolution_select |-> active[3:2] == 2'b00;
    endproperty
    a_dual_pins: assert property (p_dual_pins)
        else $error("upper inputs active in dual mode");

    property p_ctrl_write;
        wr_hit |=> ctrl_q.input_enable == $past(bus_req.wdata[3:0])
            && ctrl_q.converter_on == $past(bus_req.wdata[SAC_ON_POS]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not captured");

    property p_dual_result;
        complete && !ctrl_q.resolution_select && active[0]
            |=> result_q[3:0] == $past(code[0][3:0]);
    endproperty
    a_dual_result: assert property (p_dual_result)
        else $error("channel 0 result misplaced");

    property p_wide_result;
        complete && ctrl_q.resolution_select |=> result_q == {2'b00, $past(code[sel])};
    endproperty
    a_wide_result: assert property (p_wide_result)
        else $error("wide result misplaced");

    property p_read_result;
        rd_hit |=> rd_data == $past(result_q) ##1 rd_data == SAC_IDLE_RDATA || $past(rd_hit);
    endproperty
    a_read_result: assert property (p_read_result)
        else $error("read did not return result");

    property p_result_stable;
        !complete |=> $stable(result_q);
    endproperty
    a_result_stable: assert property (p_result_stable)
        else $error("result changed between refreshes");

    property p_unmapped_read;
        bus_req.rd && bus_req.addr != SAC_CTRL_ADDR |=> rd_data == SAC_IDLE_RDATA;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned data");

    property p_unmapped_write;
        bus_req.wr && bus_req.addr != SAC_CTRL_ADDR |=> $stable(ctrl_q);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("unmapped write changed control");

    property p_mode_write;
        wr_hit
            |=> ctrl_q.resolution_select == $past(bus_req.wdata[SAC_MODE_POS]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode bit not captured");

    property p_dual_result_hi;
        complete && !ctrl_q.resolution_select && active[1]
            |=> result_q[7:4] == $past(code[1][3:0]);
    endproperty
    a_dual_result_hi: assert property (p_dual_result_hi)
        else $error("channel 1 result misplaced");

    property p_timer_off;
        !ctrl_q.converter_on |-> !tick;
    endproperty
    a_timer_off: assert property (p_timer_off)
        else $error("refresh tick while converter off");

    c_dual_round: cover property (complete && !ctrl_q.resolution_select && active == 4'h3);
    c_wide_round: cover property (complete && ctrl_q.resolution_select);
    c_abort_round: cover property (state_q == SAC_CONV && abort);
    c_read_back: cover property (rd_hit && result_q != 8'h00);
    c_off_write: cover property (wr_hit && !bus_req.wdata[SAC_ON_POS]);

endmodule

//--- sac_pkg.sv
// Shared constants and carrier types for the step-compare converter control.
// Assumes a single 25 MHz system clock that also serves as the oscillator.
package sac_pkg;

    // Channel and code geometry
    localparam int SAC_NUM_CH       = 4;
    localparam int SAC_CODE_W       = 6;
    localparam int SAC_NARROW_W     = 4;
    localparam int SAC_NARROW_STEPS = 16;
    localparam int SAC_WIDE_STEPS   = 64;
    // Narrow codes drive the shared 64-step ladder scaled up by this shift
    localparam int SAC_NARROW_SHIFT = $clog2(SAC_WIDE_STEPS / SAC_NARROW_STEPS);

    // Register map and field positions
    localparam logic [7:0] SAC_CTRL_ADDR    = 8'hA0;
    localparam int         SAC_ON_POS       = 7;
    localparam int         SAC_MODE_POS     = 6;
    localparam int         SAC_EN_LSB       = 0;
    localparam logic [7:0] SAC_RESULT_RESET = 8'h00;
    localparam logic [7:0] SAC_IDLE_RDATA   = 8'h00;

    // Timing: refresh periods in oscillator periods, settle time in ns
    localparam int SAC_CLK_NS             = 40;
    localparam int SAC_OSC_NS             = 40;
    localparam int SAC_REFRESH_NARROW_OSC = 6144;
    localparam int SAC_REFRESH_WIDE_OSC   = 12288;
    localparam int SAC_REFRESH_NARROW_CYC = (SAC_REFRESH_NARROW_OSC * SAC_OSC_NS) / SAC_CLK_NS;
    localparam int SAC_REFRESH_WIDE_CYC   = (SAC_REFRESH_WIDE_OSC * SAC_OSC_NS) / SAC_CLK_NS;
    localparam int SAC_SETTLE_NS          = 400;
    localparam int SAC_SETTLE_CYC         = (SAC_SETTLE_NS + SAC_CLK_NS - 1) / SAC_CLK_NS;
    localparam int SAC_TIMER_W            = 14;

    typedef struct packed {
        logic       converter_on;
        logic       resolution_select;
        logic [3:0] input_enable;
    } sac_ctrl_t;

    localparam sac_ctrl_t SAC_CTRL_RESET = '{converter_on: 1'b0, resolution_select: 1'b0,
                                             input_enable: 4'h0};

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sac_bus_req_t;

endpackage

//--- sac_refresh_timer.sv
// Refresh period timer: one tick per period, period chosen by resolution.
// Assumes the caller restarts it whenever the mode may have changed.
`timescale 1ns/1ps
module sac_refresh_timer #(
    parameter int PERIOD_NARROW = sac_pkg::SAC_REFRESH_NARROW_CYC,
    parameter int PERIOD_WIDE   = sac_pkg::SAC_REFRESH_WIDE_CYC,
    parameter int CNT_W         = sac_pkg::SAC_TIMER_W
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Control
    input  wire logic run,
    input  wire logic wide,
    input  wire logic restart,
    // Event
    output logic      tick
);
    import sac_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] last;
    logic             tick_q;
    logic             tick_d;

    always_comb begin
        last   = wide ? CNT_W'(PERIOD_WIDE - 1) : CNT_W'(PERIOD_NARROW - 1);
        cnt_d  = cnt_q + CNT_W'(1);
        tick_d = 1'b0;
        if (!run || restart) begin
            cnt_d = '0;
        end else if (cnt_q == last) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule

//--- sac_sar_chan.sv
// One successive-approximation channel driving a 64-step supply ladder.
// Assumes cmp_above is high when the pin sits above the ladder output.
`timescale 1ns/1ps
module sac_sar_chan #(
    parameter int SETTLE = sac_pkg::SAC_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Control
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic       wide,
    // Analog front end
    input  wire logic       cmp_above,
    output logic [5:0]      ref_code,
    // Result
    output logic [5:0]      code,
    output logic            done
);
    import sac_pkg::*;

    localparam int SET_W = $clog2(SETTLE + 1);

    typedef enum logic {SAC_S_IDLE, SAC_S_TRIAL} sac_sar_st_t;

    sac_sar_st_t      st_q, st_d;
    logic [5:0]       acc_q, acc_d, mask_q, mask_d, ref_q, ref_d, code_q, code_d;
    logic [5:0]       trial, acc_new, nxt;
    logic [SET_W-1:0] settle_q, settle_d;
    logic             wide_q, wide_d, done_q, done_d;

    always_comb begin
        st_d     = st_q;
        acc_d    = acc_q;
        mask_d   = mask_q;
        settle_d = settle_q;
        wide_d   = wide_q;
        code_d   = code_q;
        done_d   = 1'b0;
        trial    = acc_q | mask_q;
        acc_new  = cmp_above ? trial : acc_q;
        case (st_q)
            SAC_S_IDLE: begin
                if (start) begin
                    acc_d    = 6'h00;
                    mask_d   = wide ? 6'h20 : 6'h08;
                    settle_d = SET_W'(SETTLE - 1);
                    wide_d   = wide;
                    st_d     = SAC_S_TRIAL;
                end
            end
            SAC_S_TRIAL: begin
                if (abort) begin
                    // Drop the trial too, so the ladder rests at zero while idle
                    acc_d  = 6'h00;
                    mask_d = 6'h00;
                    st_d   = SAC_S_IDLE;
                end else if (settle_q != '0) begin
                    settle_d = settle_q - SET_W'(1);
                end else if (mask_q == 6'h01) begin
                    code_d = acc_new;
                    done_d = 1'b1;
                    acc_d  = 6'h00;
                    mask_d = 6'h00;
                    st_d   = SAC_S_IDLE;
                end else begin
                    acc_d    = acc_new;
                    mask_d   = mask_q >> 1;
                    settle_d = SET_W'(SETTLE - 1);
                end
            end
            default: st_d = SAC_S_IDLE;
        endcase
        nxt   = acc_d | mask_d;
        // Narrow step N lands on ladder step 4N, i.e. supply*N/16
        ref_d = wide_d ? nxt : 6'(nxt << SAC_NARROW_SHIFT);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q     <= SAC_S_IDLE;
            acc_q    <= 6'h00;
            mask_q   <= 6'h00;
            settle_q <= '0;
            wide_q   <= 1'b0;
            ref_q    <= 6'h00;
            code_q   <= 6'h00;
            done_q   <= 1'b0;
        end else begin
            st_q     <= st_d;
            acc_q    <= acc_d;
            mask_q   <= mask_d;
            settle_q <= settle_d;
            wide_q   <= wide_d;
            ref_q    <= ref_d;
            code_q   <= code_d;
            done_q   <= done_d;
        end
    end

    assign ref_code = ref_q;
    assign code     = code_q;
    assign done     = done_q;

endmodule

//--- sac_adc_ctrl_tb.sv
// Self-checking bench for the converter control top.
// Assumes ideal comparators driven from the ladder codes and the pin levels below.
`timescale 1ns/1ps
module testbench;
    import sac_pkg::*;

    localparam int PN = 64;
    localparam int PW = 128;

    logic                 sys_clk;
    logic                 resetn;
    sac_bus_req_t         bus_req;
    logic [7:0]           rd_data;
    logic [3:0]           cmp_above;
    logic [3:0]           pin_enable;
    logic [3:0][5:0]      ref_code;
    // Pin levels in supply/128 units, always odd so never on a step
    logic [6:0]           pin [4];
    int                   miscompares;
    int                   check_count;
    int                   cyc;
    logic [7:0]           rv;
    logic [7:0]           last;
    logic [3:0]           en;
    int                   t0;
    int                   t1;
    int                   busy;

    sac_adc_ctrl #(
        .REFRESH_NARROW_CYC (PN),
        .REFRESH_WIDE_CYC   (PW),
        .SETTLE_CYC         (2)
    ) i_dut (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .bus_req    (bus_req),
        .rd_data    (rd_data),
        .cmp_above  (cmp_above),
        .pin_enable (pin_enable),
        .ref_code   (ref_code)
    );

    // Ideal comparator per channel against the 64-step ladder
    for (genvar g = 0; g < 4; g++) begin : g_cmp
        assign cmp_above[g] = pin[g] > {ref_code[g], 1'b0};
    end

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            summarize();
        end
    end

    // A disabled channel keeps its old nibble
    function automatic logic [7:0] exp_dual(logic [7:0] prev, logic [1:0] on,
                                            logic [6:0] p1, logic [6:0] p0);
        return {on[1] ? p1[6:3] : prev[7:4], on[0] ? p0[6:3] : prev[3:0]};
    endfunction

    function automatic logic [7:0] exp_wide(logic [6:0] p);
        return {2'b00, p[6:1]};
    endfunction

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic bus_write(logic [7:0] addr, logic [7:0] data);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    endtask

    // Read data stands one cycle only, zero afterwards
    task automatic bus_read(logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
        #1;
        data = rd_data;
        @(posedge sys_clk);
        #1;
        check("rd_data idle", rd_data, 8'h00);
    endtask

    task automatic wait_cyc(int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic rand_pins();
        for (int i = 0; i < 4; i++)
            pin[i] = 7'((($urandom % 64) << 1) | 1);
    endtask

    // Cycle stamp of the next round start, seen as ladder of input 0 leaving idle
    task automatic wait_round(output int t);
        bit prev;
        prev = 1'b1;
        for (int n = 0; n < 400; n++) begin
            @(posedge sys_clk);
            #1;
            if (!prev && ref_code[0] != 6'h00)
                break;
            prev = (ref_code[0] != 6'h00);
        end
        t = cyc;
    endtask

    initial begin
        miscompares = 0;
        check_count = 0;
        cyc = 0;
        resetn = 1'b0;
        bus_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
        for (int i = 0; i < 4; i++)
            pin[i] = 7'h01;
        void'($urandom(32'h71B8));
        wait_cyc(5);
        resetn <= 1'b1;
        #1;
        check("pin_enable reset", {4'h0, pin_enable}, 8'h00);
        bus_read(8'hA0, rv);
        check("result reset", rv, SAC_RESULT_RESET);
        last = SAC_RESULT_RESET;

        // Dual 4-bit: random levels, enables and ignored bits, plus both range ends
        for (int k = 0; k < 10; k++) begin
            rand_pins();
            en = 4'($urandom % 16);
            if (k == 0) begin
                pin[0] = 7'h01;
                pin[1] = 7'h7F;
                en     = 4'hF;
            end
            // Last round converts both, so rounds run in the stability window
            if (k == 9)
                en[1:0] = 2'b11;
            bus_write(8'hA0, 8'h80 | 8'(($urandom % 4) << 4) | {4'h0, en});
            #1;
            check("pin_enable dual", {4'h0, pin_enable}, {6'h00, en[1:0]});
            wait_cyc(PN + PN / 2);
            bus_read(8'hA0, rv);
            last = exp_dual(last, en[1:0], pin[1], pin[0]);
            check("dual result", rv, last);
            check("dual result", rv, last);
        end

        // Result stays put between rounds
        for (int k = 0; k < 3; k++) begin
            wait_cyc(PN / 3);
            bus_read(8'hA0, rv);
            check("result stable", rv, last);
        end

        // Unmapped address: write ignored, read gives zero
        bus_write(8'hA1, 8'h00);
        #1;
        check("pin_enable after unmapped", {4'h0, pin_enable}, {6'h00, en[1:0]});
        bus_read(8'hA1, rv);
        check("unmapped read", rv, 8'h00);

        // Converter off: no rounds, result keeps last value
        bus_write(8'hA0, 8'h03);
        #1;
        check("pin_enable off", {4'h0, pin_enable}, 8'h00);
        rand_pins();
        busy = 0;
        for (int n = 0; n < 2 * PN; n++) begin
            @(posedge sys_clk);
            #1;
            if (ref_code != '0)
                busy = busy + 1;
        end
        check("rounds while off", 8'(busy), 8'h00);
        bus_read(8'hA0, rv);
        check("result held off", rv, last);

        // Refresh spacing in both modes
        bus_write(8'hA0, 8'h81);
        wait_round(t0);
        wait_round(t1);
        check("narrow period", 8'(t1 - t0), 8'(PN));
        bus_write(8'hA0, 8'hC1);
        wait_round(t0);
        wait_round(t1);
        check("wide period", 8'(t1 - t0), 8'(PW));

        // Six-bit mode: one input at a time, random levels and range ends
        for (int k = 0; k < 8; k++) begin
            rand_pins();
            if (k == 0)
                pin[0] = 7'h01;
            if (k == 4)
                pin[0] = 7'h7F;
            // Only one enable set at a time in this mode
            bus_write(8'hA0, 8'hC0 | 8'(($urandom % 4) << 4) | 8'(1 << (k % 4)));
            #1;
            check("pin_enable wide", {4'h0, pin_enable}, 8'(1 << (k % 4)));
            wait_cyc(PW + PW / 2);
            bus_read(8'hA0, rv);
            check("wide result", rv, exp_wide(pin[k % 4]));
            check("wide result", rv, exp_wide(pin[k % 4]));
        end

        // Back-to-back write then read: read gives result, not control value
        bus_write(8'hA0, 8'hC1);
        bus_read(8'hA0, rv);
        check("read not control", rv, exp_wide(pin[3]));

        // Reset in mid-run: control and result go back to their reset values
        @(posedge sys_clk);
        resetn <= 1'b0;
        wait_cyc(3);
        resetn <= 1'b1;
        #1;
        check("pin_enable mid reset", {4'h0, pin_enable}, 8'h00);
        bus_read(8'hA0, rv);
        check("result mid reset", rv, SAC_RESULT_RESET);
        summarize();
    end
endmodule
